// file: llcpc_pkg.sv
// constants, types and helpers shared by the line-locked clock phase control
// assumes a single 125 MHz system clock; all other rates are derived enables
package llcpc_pkg;

    // system clock
    localparam int CLK_PERIOD_NS = 8;

    // phase reference delay after the line sync falling edge (least time)
    localparam int REF_DELAY_NS  = 110;
    localparam int REF_DELAY_CYC =
        (REF_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // static phase error limit for a low lock indicator (longest time)
    localparam int LOCK_ERR_NS   = 50;
    localparam int LOCK_ERR_CYC  = LOCK_ERR_NS / CLK_PERIOD_NS;

    // phase error above which fast-lock corrects the clock (longest time)
    localparam int FAST_ERR_NS   = 200;
    localparam int FAST_ERR_CYC  = FAST_ERR_NS / CLK_PERIOD_NS;

    // widths
    localparam int DLY_W  = 5;
    localparam int ERR_W  = 16;
    localparam int DIV_W  = 11;
    localparam int SEL_W  = 3;

    localparam logic [DLY_W-1:0] REF_DELAY_LD = DLY_W'(REF_DELAY_CYC);
    localparam logic [DLY_W-1:0] DLY_ONE      = 5'h01;
    localparam logic [ERR_W-1:0] LOCK_ERR_LIM = ERR_W'(LOCK_ERR_CYC);
    localparam logic [ERR_W-1:0] FAST_ERR_LIM = ERR_W'(FAST_ERR_CYC);
    localparam logic [ERR_W-1:0] ERR_MAX      = 16'hffff;

    // register map, byte addresses of aligned 32-bit words
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_PHASE  = 8'h08;

    // control register fields
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_FBI_BIT = 3;
    localparam logic [3:0] CTRL_RST = 4'hf;

    // status register fields
    localparam int ST_LOCK_BIT = 0;
    localparam int ST_SRC_BIT  = 1;
    localparam int ST_SNK_BIT  = 2;
    localparam int ST_INH_BIT  = 3;
    localparam int ST_MODE_LSB = 4;

    // ahb-lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;

    // loop operating mode, one-hot
    typedef enum logic [2:0] {
        MODE_NORMAL = 3'h1,
        MODE_FAST   = 3'h2,
        MODE_COAST  = 3'h4
    } llcpc_mode_type;

    // internal divisor after the divide-by-two stage, per select code
    function automatic logic [DIV_W-1:0] div_count(input logic [SEL_W-1:0] s);
        logic [DIV_W-1:0] n;
        n = 11'h38e;
        unique case (s)
            3'h0: n = 11'h353;
            3'h1: n = 11'h360;
            3'h2: n = 11'h3b0;
            3'h3: n = 11'h46f;
            3'h4: n = 11'h2aa;
            3'h5: n = 11'h35a;
            3'h6: n = 11'h30c;
            3'h7: n = 11'h38e;
        endcase
        return n;
    endfunction

endpackage

// file: llcpc_sync.sv
// two-flop synchroniser for pin inputs
// assumes inputs are asynchronous to clk_sys_i
module llcpc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_reg;

    // first stage is read only by the second stage
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            q_o      <= '0;
        end else begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end
endmodule // llcpc_sync

// file: llcpc_div.sv
// internal feedback divider: divide by two, then by a selectable count
// assumes tick_i is a one-cycle pulse per oscillator rising edge
module llcpc_div (
    input  wire logic                      clk_sys_i,
    input  wire logic                      rst_i,
    input  wire logic                      tick_i,
    input  wire logic                      reload_i,
    input  wire logic [llcpc_pkg::DIV_W-1:0] count_i,
    output logic                           fb_o
);
    logic                          half_reg;
    logic [llcpc_pkg::DIV_W-1:0]   cnt_reg;
    logic [llcpc_pkg::DIV_W-1:0]   cnt_next;
    logic                          adv;

    assign adv      = tick_i & half_reg;
    assign cnt_next = (cnt_reg >= count_i - 11'h001) ? '0 : cnt_reg + 11'h001;

    // reload restarts at the rising feedback edge
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            half_reg <= 1'b0;
            cnt_reg  <= '0;
            fb_o     <= 1'b0;
        end else if (reload_i) begin
            half_reg <= 1'b0;
            cnt_reg  <= '0;
            fb_o     <= 1'b1;
        end else begin
            if (tick_i)
                half_reg <= ~half_reg;
            if (adv)
                cnt_reg <= cnt_next;
            fb_o <= (cnt_reg < (count_i >> 1));
        end
    end
endmodule // llcpc_div

// file: llcpc_top.sv
// digital control of a line-locked pixel clock loop with ahb-lite registers
// assumes osc, line sync, feedback pin and mode comparators are async pins
module llcpc_top (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    // ahb-lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    // loop pins
    input  wire logic        osc_i,
    input  wire logic        line_sync_i,
    input  wire logic        mode_hi_i,
    input  wire logic        mode_lo_i,
    input  wire logic        ext_div_i,
    output logic             ext_div_o,
    output logic             ext_div_oe_o,
    output logic             clk_out_o,
    output logic             pump_src_o,
    output logic             pump_snk_o,
    output logic             pump_oe_o,
    output logic             lock_indicator_o
);
    // synchronised pins
    logic [4:0]                   pins_s;
    logic                         osc_s;
    logic                         sync_s;
    logic                         ext_s;
    logic                         mhi_s;
    logic                         mlo_s;

    // edge detection
    logic                         osc_prev_reg;
    logic                         sync_prev_reg;
    logic                         fb_prev_reg;
    logic                         osc_rise;
    logic                         sync_fall;
    logic                         fb_lvl;
    logic                         fb_rise;

    // reference delay
    logic [llcpc_pkg::DLY_W-1:0]  dly_reg;
    logic [llcpc_pkg::DLY_W-1:0]  dly_next;
    logic                         ref_pulse;

    // mode
    llcpc_pkg::llcpc_mode_type    mode_reg;
    llcpc_pkg::llcpc_mode_type    mode_next;
    logic                         pd_en;
    logic                         fast_en;

    // phase/frequency detector
    logic                         up_reg;
    logic                         dn_reg;
    logic                         up_set;
    logic                         dn_set;
    logic                         up_n;
    logic                         dn_n;
    logic                         match;
    logic                         up_next;
    logic                         dn_next;
    logic [llcpc_pkg::ERR_W-1:0]  err_reg;
    logic [llcpc_pkg::ERR_W-1:0]  err_next;
    logic [llcpc_pkg::ERR_W-1:0]  err_done;
    logic signed [llcpc_pkg::ERR_W:0] phase_reg;
    logic signed [llcpc_pkg::ERR_W:0] phase_next;
    logic                         big_err;
    logic                         small_err;
    logic                         lock_next;

    // fast-lock correction
    logic                         inhibit_reg;
    logic                         inhibit_next;
    logic                         reload;

    // divider
    logic                         div_fb;
    logic                         div_tick;
    logic [llcpc_pkg::DIV_W-1:0]  div_n;

    // registers and bus
    logic [3:0]                   ctrl_reg;
    logic                         fb_int;
    logic                         wr_pend_reg;
    logic [7:0]                   addr_reg;
    logic                         acc;
    logic                         word_ok;
    logic [31:0]                  rd_mux;
    logic                         in_map;
    logic                         hit_ctrl;
    logic                         hit_status;
    logic                         hit_phase;
    logic                         wr_take;
    logic                         rd_take;
    logic                         ctrl_wr;
    logic [31:0]                  status_word;
    logic [31:0]                  phase_word;

    llcpc_sync #(
        .WIDTH (5)
    ) u_sync (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .d_i       ({osc_i, line_sync_i, ext_div_i, mode_hi_i, mode_lo_i}),
        .q_o       (pins_s)
    );

    assign osc_s  = pins_s[4];
    assign sync_s = pins_s[3];
    assign ext_s  = pins_s[2];
    assign mhi_s  = pins_s[1];
    assign mlo_s  = pins_s[0];

    assign fb_int = ctrl_reg[llcpc_pkg::CTRL_FBI_BIT];
    assign div_n  = llcpc_pkg::div_count(
                        ctrl_reg[llcpc_pkg::CTRL_SEL_LSB +: llcpc_pkg::SEL_W]);

    // edges
    assign osc_rise  = osc_s & ~osc_prev_reg;
    assign sync_fall = ~sync_s & sync_prev_reg;
    // feedback source: internal divider or external chain
    assign fb_lvl    = fb_int ? div_fb : ext_s;
    assign fb_rise   = fb_lvl & ~fb_prev_reg;

    // delayed reference; a new falling edge restarts the delay
    assign dly_next  = sync_fall ? llcpc_pkg::REF_DELAY_LD :
                       (dly_reg != '0) ? dly_reg - 5'h01 : '0;
    assign ref_pulse = (dly_reg == llcpc_pkg::DLY_ONE);

    // three-level input: below 1/3 normal, above 2/3 coast, else fast
    // both comparators high cannot happen on a real pin; treated as coast
    assign mode_next = mhi_s ? llcpc_pkg::MODE_COAST :
                       mlo_s ? llcpc_pkg::MODE_NORMAL :
                               llcpc_pkg::MODE_FAST;
    assign pd_en   = (mode_reg != llcpc_pkg::MODE_COAST);
    assign fast_en = (mode_reg == llcpc_pkg::MODE_FAST);

    // phase/frequency detector: first edge raises its flag, second clears
    assign up_set  = pd_en & ref_pulse;
    assign dn_set  = pd_en & fb_rise;
    assign up_n    = up_reg | up_set;
    assign dn_n    = dn_reg | dn_set;
    assign match   = up_n & dn_n;
    assign up_next = pd_en & up_n & ~match;
    assign dn_next = pd_en & dn_n & ~match;

    // error width in cycles, saturating
    assign err_done = (err_reg == llcpc_pkg::ERR_MAX) ? err_reg :
                      err_reg + 16'h0001;
    assign err_next = (!pd_en || match) ? '0 :
                      (up_n | dn_n) ? err_done : '0;

    // feedback lagging the reference reads positive, leading negative
    assign phase_next = up_reg ? $signed({1'b0, err_reg}) :
                        dn_reg ? -$signed({1'b0, err_reg}) :
                                 '0;

    assign small_err = (err_reg < llcpc_pkg::LOCK_ERR_LIM);
    assign big_err   = (err_reg >= llcpc_pkg::FAST_ERR_LIM);

    // indicator goes high once an error reaches the lock limit, low after a small match
    assign lock_next = !pd_en ? lock_indicator_o :
                       match ? ~small_err :
                       ((up_reg | dn_reg) && !small_err) ? 1'b1 :
                       lock_indicator_o;

    // fast-lock: a late feedback edge is forced by restarting the divider,
    // an early one stalls the clock until the reference arrives
    // limitation: with sync lost mid-stall the clock stays held until it returns
    assign reload       = fast_en & up_reg & ~dn_n & big_err;
    assign inhibit_next = fast_en & ~ref_pulse &
                          (inhibit_reg | (dn_reg & ~up_n & big_err));

    // divide by two then by N inside the divider, from the passed clock
    assign div_tick = osc_rise & ~inhibit_reg;

    llcpc_div u_div (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .tick_i    (div_tick),
        .reload_i  (reload),
        .count_i   (div_n),
        .fb_o      (div_fb)
    );

    // edges, mode and delay
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            osc_prev_reg  <= 1'b0;
            sync_prev_reg <= 1'b0;
            fb_prev_reg   <= 1'b0;
            dly_reg       <= '0;
            mode_reg      <= llcpc_pkg::MODE_NORMAL;
        end else begin
            osc_prev_reg  <= osc_s;
            sync_prev_reg <= sync_s;
            fb_prev_reg   <= fb_lvl;
            dly_reg       <= dly_next;
            mode_reg      <= mode_next;
        end
    end

    // detector state and measurements
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            up_reg    <= 1'b0;
            dn_reg    <= 1'b0;
            err_reg   <= '0;
            phase_reg <= '0;
        end else begin
            up_reg  <= up_next;
            dn_reg  <= dn_next;
            err_reg <= err_next;
            if (match)
                phase_reg <= phase_next;
        end
    end

    // pin outputs, all registered
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pump_src_o       <= 1'b0;
            pump_snk_o       <= 1'b0;
            pump_oe_o        <= 1'b0;
            lock_indicator_o <= 1'b1;
            inhibit_reg      <= 1'b0;
            clk_out_o        <= 1'b0;
            ext_div_o        <= 1'b0;
            ext_div_oe_o     <= 1'b0;
        end else begin
            pump_src_o       <= up_next;
            pump_snk_o       <= dn_next;
            pump_oe_o        <= up_next | dn_next;
            lock_indicator_o <= lock_next;
            inhibit_reg      <= inhibit_next;
            // gating costs three system clocks (24 ns) of latency but keeps one clock domain
            clk_out_o        <= osc_s & ~inhibit_next;
            ext_div_o        <= fb_int & div_fb;
            ext_div_oe_o     <= fb_int;
        end
    end

    // ahb-lite slave, zero wait states
    assign acc     = hsel_i & hready_i & htrans_i[1];
    assign word_ok = (hsize_i == llcpc_pkg::HSIZE_WORD);

    // only the low byte decodes; any upper address bit misses the map
    assign in_map     = (haddr_i[31:8] == 24'h000000);
    assign hit_ctrl   = in_map & (haddr_i[7:0] == llcpc_pkg::ADDR_CTRL);
    assign hit_status = in_map & (haddr_i[7:0] == llcpc_pkg::ADDR_STATUS);
    assign hit_phase  = in_map & (haddr_i[7:0] == llcpc_pkg::ADDR_PHASE);
    // narrow writes are dropped rather than merged into the control word
    assign wr_take    = acc & hwrite_i & word_ok & in_map;
    assign rd_take    = acc & ~hwrite_i;

    // status fields placed by name so the layout lives in the package
    assign status_word[llcpc_pkg::ST_LOCK_BIT] = lock_indicator_o;
    assign status_word[llcpc_pkg::ST_SRC_BIT]  = pump_src_o;
    assign status_word[llcpc_pkg::ST_SNK_BIT]  = pump_snk_o;
    assign status_word[llcpc_pkg::ST_INH_BIT]  = inhibit_reg;
    assign status_word[llcpc_pkg::ST_MODE_LSB +: $bits(mode_reg)] = mode_reg;
    assign status_word[31:llcpc_pkg::ST_MODE_LSB + $bits(mode_reg)] = '0;

    // phase is sign-extended so software reads a plain signed word
    assign phase_word =
        {{(32 - llcpc_pkg::ERR_W - 1){phase_reg[llcpc_pkg::ERR_W]}},
         phase_reg};

    assign rd_mux = hit_ctrl   ? {28'h0000000, ctrl_reg} :
                    hit_status ? status_word :
                    hit_phase  ? phase_word :
                                 32'h00000000;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            wr_pend_reg <= 1'b0;
            addr_reg    <= '0;
            hrdata_o    <= '0;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end else begin
            wr_pend_reg <= wr_take;
            addr_reg    <= haddr_i[7:0];
            if (rd_take)
                hrdata_o <= rd_mux;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end
    end

    // only the control word is writable; data arrives a cycle after address
    assign ctrl_wr = wr_pend_reg & (addr_reg == llcpc_pkg::ADDR_CTRL);

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i)
            ctrl_reg <= llcpc_pkg::CTRL_RST;
        else if (ctrl_wr)
            ctrl_reg <= hwdata_i[3:0];
    end

endmodule // llcpc_top

// file: llcpc_top_assertions.sv
// checker for llcpc_top: pump, mode and feedback timing at the pins
// assumes bound into llcpc_top; pins change away from the clock edge
module llcpc_top_assertions (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic osc_i,
    input wire logic line_sync_i,
    input wire logic mode_hi_i,
    input wire logic mode_lo_i,
    input wire logic ext_div_i,
    input wire logic ext_div_o,
    input wire logic ext_div_oe_o,
    input wire logic clk_out_o,
    input wire logic pump_src_o,
    input wire logic pump_snk_o,
    input wire logic pump_oe_o,
    input wire logic lock_indicator_o
);
    logic [7:0] sync_age_reg;
    logic [7:0] fb_age_reg;
    logic [3:0] run_reg;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    // ages saturate so long idle stretches never wrap into a window
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            sync_age_reg <= 8'hff;
            fb_age_reg   <= 8'hff;
            run_reg      <= 4'h0;
        end else begin
            sync_age_reg <= $fell(line_sync_i) ? 8'h00 :
                sync_age_reg + {7'h0, sync_age_reg != 8'hff};
            fb_age_reg   <= $rose(ext_div_i) ? 8'h00 :
                fb_age_reg + {7'h0, fb_age_reg != 8'hff};
            run_reg      <= !pump_oe_o ? 4'h0 :
                run_reg + {3'h0, run_reg != 4'hf};
        end
    end

    a_pump_one_way: assert property (!(pump_src_o && pump_snk_o))
        else $error("pump sources and sinks at once");
    a_pump_oe_pair: assert property (pump_oe_o == (pump_src_o | pump_snk_o))
        else $error("pump enable disagrees with pump drive");
    a_ext_pin_quiet: assert property (!ext_div_oe_o |-> !ext_div_o)
        else $error("feedback pin driven while released");
    a_coast_pump_off: assert property (mode_hi_i [*6] |-> !pump_oe_o)
        else $error("pump active in coast");
    a_coast_lock_held: assert property (mode_hi_i [*6] |=> $stable(lock_indicator_o))
        else $error("lock indicator moved in coast");
    a_src_from_ref: assert property ($rose(pump_src_o) |-> sync_age_reg inside {[14:20]})
        else $error("pump source not tied to delayed sync");
    a_snk_from_fb: assert property ($rose(pump_snk_o) && !ext_div_oe_o |-> fb_age_reg inside {[1:6]})
        else $error("pump sink not tied to feedback edge");
    a_long_err_unlock: assert property (run_reg == 4'h8 |=> lock_indicator_o)
        else $error("long phase error left indicator low");
    a_clk_tracks_osc: assert property ((mode_lo_i || mode_hi_i) [*6] |-> clk_out_o == $past(osc_i, 3))
        else $error("clock output does not follow oscillator");

    cover property ($rose(pump_src_o));
    cover property ($rose(pump_snk_o));
    cover property ($fell(lock_indicator_o));
    cover property (!mode_lo_i && !mode_hi_i && pump_snk_o);
endmodule // llcpc_top_assertions

bind llcpc_top llcpc_top_assertions chk (.*);

// file: llcpc_sync_src.sv
// line sync source: one falling-edge sync pulse per fire request
// assumes fire_i is raised by the bench one cycle ahead of the fall
module llcpc_sync_src #(
    parameter int LOW_CYC = 32
) (
    input  wire logic clk_i,
    input  wire logic fire_i,
    output logic      line_sync_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] low_cnt_reg = 8'h00;

    // pin idles high; the falling edge leads each pulse
    always_ff @(posedge clk_i) begin
        if (fire_i)
            low_cnt_reg <= 8'(LOW_CYC);
        else if (low_cnt_reg != 8'h00)
            low_cnt_reg <= low_cnt_reg - 8'h01;
    end

    assign line_sync_o = (low_cnt_reg == 8'h00);
endmodule // llcpc_sync_src

// file: testbench.sv
// testbench: bus access, loop transfers and divider timing of llcpc_top
// assumes osc at three clocks a period, offset from the clock edges
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_sys_i, rst_i, hsel_i, hwrite_i, hready_i, fire;
    logic        osc_i, line_sync_i, mode_hi_i, mode_lo_i, ext_div_i;
    logic [1:0]  htrans_i;
    logic [2:0]  hsize_i;
    logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
    logic        hreadyout_o, hresp_o, ext_div_o, ext_div_oe_o, clk_out_o;
    logic        pump_src_o, pump_snk_o, pump_oe_o, lock_indicator_o, prev;
    int          n_errors, num_checks, cyc, n_src, n_snk, n_rise, p;
    int          low_run, max_low;
    int          err_tab [6] = '{20, -10, 2, -5, 6, 5};
    int          sel_tab [3] = '{4, 6, 0};
    int          div_tab [3] = '{682, 780, 851};

    assign hready_i = hreadyout_o;
    llcpc_top uut (.*);
    llcpc_sync_src sep (.clk_i(clk_sys_i), .fire_i(fire),
                        .line_sync_o(line_sync_i));

    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    // osc edges never meet a clock edge, so the capture is deterministic
    initial begin
        osc_i = 1'b0;
        #2;
        forever #12 osc_i = ~osc_i;
    end

    always @(posedge clk_sys_i) begin
        cyc++;
        if (pump_src_o === 1'b1) n_src++;
        if (pump_snk_o === 1'b1) n_snk++;
        if (clk_out_o === 1'b1 && prev === 1'b0) n_rise++;
        prev = clk_out_o;
        low_run = (clk_out_o === 1'b0) ? low_run + 1 : 0;
        if (low_run > max_low) max_low = low_run;
        if (cyc == 60000) begin
            n_errors++;
            $display("ERROR timeout");
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    // entered right after a rising edge; zero-wait slave still waited on
    task automatic bus(input logic wr, input logic [31:0] a,
                       input logic [31:0] d);
        hsel_i   <= 1'b1;
        htrans_i <= 2'h2;
        haddr_i  <= a;
        hwrite_i <= wr;
        hsize_i  <= 3'h2;
        @(posedge clk_sys_i);
        while (hreadyout_o !== 1'b1) @(posedge clk_sys_i);
        hsel_i   <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        @(posedge clk_sys_i);
        while (hreadyout_o !== 1'b1) @(posedge clk_sys_i);
        rd = hrdata_o;
        chk("hresp", 32'h0, 32'(hresp_o));
    endtask

    // d: feedback rise minus sync fall, in clocks, at the pins
    task automatic xfer(input int d);
        n_src = 0;
        n_snk = 0;
        if (d < 0) begin
            ext_div_i <= 1'b1;
            repeat (-d - 1) @(posedge clk_sys_i);
        end
        fire <= 1'b1;
        @(posedge clk_sys_i);
        fire <= 1'b0;
        if (d >= 0) begin
            repeat (d) @(posedge clk_sys_i);
            ext_div_i <= 1'b1;
        end
        repeat (80) @(posedge clk_sys_i);
        ext_div_i <= 1'b0;
        repeat (40) @(posedge clk_sys_i);
    endtask

    task automatic fb_period(output int q);
        q = 0;
        // skip two rises: enable or a select change can cut the first period
        repeat (2) begin
            while (ext_div_o !== 1'b0) @(posedge clk_sys_i);
            while (ext_div_o !== 1'b1) @(posedge clk_sys_i);
        end
        while (ext_div_o !== 1'b0) begin @(posedge clk_sys_i); q++; end
        while (ext_div_o !== 1'b1) begin @(posedge clk_sys_i); q++; end
    endtask

    initial begin
        {rst_i, mode_lo_i} = 2'h3;
        {hsel_i, hwrite_i, fire, mode_hi_i, ext_div_i, prev} = 6'h00;
        {htrans_i, hsize_i, haddr_i, hwdata_i} = 69'h0;
        {n_errors, num_checks, cyc, n_rise, low_run, max_low} = '0;
        repeat (8) @(posedge clk_sys_i);
        chk("lock at reset", 32'h1, 32'(lock_indicator_o));
        chk("pump at reset", 32'h0, 32'(pump_oe_o));
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        bus(1'b0, 32'h00, 32'h0);
        chk("ctrl reset", 32'hf, rd);
        chk("fb oe internal", 32'h1, 32'(ext_div_oe_o));
        bus(1'b1, 32'h00, 32'h4);
        bus(1'b0, 32'h00, 32'h0);
        chk("ctrl", 32'h4, rd);
        chk("fb oe external", 32'h0, 32'(ext_div_oe_o));
        bus(1'b0, 32'h0c, 32'h0);
        chk("unmapped", 32'h0, rd);
        bus(1'b0, 32'h04, 32'h0);
        chk("mode normal", 32'h1, 32'(rd[6:4]));
        // internal feedback left a sink pulse open; coast clears the detector
        mode_hi_i <= 1'b1;
        repeat (8) @(posedge clk_sys_i);
        chk("flush pump", 32'h0, 32'(pump_oe_o));
        mode_hi_i <= 1'b0;
        repeat (8) @(posedge clk_sys_i);
        foreach (err_tab[i]) begin
            xfer(err_tab[i] + 14);
            chk("src", err_tab[i] > 0 ? err_tab[i] : 0, n_src);
            chk("snk", err_tab[i] < 0 ? -err_tab[i] : 0, n_snk);
            chk("pump oe", 32'h0, 32'(pump_oe_o));
            chk("lock", 32'(err_tab[i] >= 6 || err_tab[i] <= -6),
                32'(lock_indicator_o));
            bus(1'b0, 32'h08, 32'h0);
            chk("phase", err_tab[i], rd);
        end
        mode_hi_i <= 1'b1;
        repeat (8) @(posedge clk_sys_i);
        bus(1'b0, 32'h04, 32'h0);
        chk("mode coast", 32'h4, 32'(rd[6:4]));
        xfer(34);
        chk("coast src", 32'h0, n_src);
        chk("coast snk", 32'h0, n_snk);
        chk("coast lock", 32'h0, 32'(lock_indicator_o));
        {mode_hi_i, mode_lo_i} <= 2'h0;
        repeat (8) @(posedge clk_sys_i);
        bus(1'b0, 32'h04, 32'h0);
        chk("mode fast", 32'h2, 32'(rd[6:4]));
        @(negedge clk_sys_i) max_low = 0;
        @(posedge clk_sys_i);
        xfer(-26);
        chk("fast inhibit", 32'h1, 32'(max_low >= 10));
        mode_lo_i <= 1'b1;
        repeat (8) @(posedge clk_sys_i);
        @(negedge clk_sys_i) {n_rise, max_low} = '0;
        repeat (300) @(posedge clk_sys_i);
        chk("clk rises", 32'd100, n_rise);
        chk("clk regular", 32'h1, 32'(max_low <= 2));
        foreach (sel_tab[i]) begin
            bus(1'b1, 32'h00, 32'(8 + sel_tab[i]));
            fb_period(p);
            chk("fb period", 6 * div_tab[i], p);
            chk("fb oe", 32'h1, 32'(ext_div_oe_o));
        end
        wrap_up();
    end
endmodule // testbench
